// File: inc/hostport_params.svh
`ifndef HOSTPORT_PARAMS_SVH
`define HOSTPORT_PARAMS_SVH

// register indices as seen on register_select
`define RI_GPIP   5'h00
`define RI_AER    5'h01
`define RI_DDR    5'h02
`define RI_IERA   5'h03
`define RI_IERB   5'h04
`define RI_PENDING_REG_A   5'h05
`define RI_PENDING_REG_B   5'h06
`define RI_ISRA   5'h07
`define RI_ISRB   5'h08
`define RI_MASK_REG_A   5'h09
`define RI_MASK_REG_B   5'h0a
`define RI_VR     5'h0b
`define RI_FIRST_TIMER_CONTROL   5'h0c
`define RI_SECOND_TIMER_CONTROL   5'h0d
`define RI_TCDCR  5'h0e
`define RI_TADR   5'h0f
`define RI_TBDR   5'h10
`define RI_TCDR   5'h11
`define RI_TDDR   5'h12
`define RI_SCR    5'h13
`define RI_UCR    5'h14
`define RI_RSR    5'h15
`define RI_TSR    5'h16
`define RI_UDR    5'h17
`define REG_COUNT 24

// reset values, field positions and synchroniser depth
`define VR_RST      8'h0f
`define TMODE_BIT   3
`define RX_EN_BIT   0
`define TX_EN_BIT   0
`define SYNC_STAGES 2

`endif

// File: inc/hostport_pkg.sv
package hostport_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] rsel_t;
  typedef enum logic [2:0] {
    S_IDLE,
    S_DRIVE,
    S_WAIT,
    S_PASS,
    S_RELEASE
  } bus_state_e;
endpackage : hostport_pkg

// File: inc/hostport_sync_if.sv
interface hostport_sync_if #(parameter int W = 5);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport dut (input raw, output synced);
endinterface : hostport_sync_if

// File: core/hostport_sync.sv
`include "hostport_params.svh"
module hostport_sync #(
  parameter int W     = 5,
  parameter int DEPTH = `SYNC_STAGES
) (
  input wire logic  clk_i,
  input wire logic  srst_i,
  hostport_sync_if.dut port
);
  import hostport_pkg::*;
  // active-low strobes idle high, so every stage resets high, the address strobe too
  logic [W-1:0] stage_r [DEPTH];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_r[i] <= '1;
      end
    end else begin
      stage_r[0] <= port.raw;
      for (int i = 1; i < DEPTH; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign port.synced = stage_r[DEPTH-1];
endmodule : hostport_sync

// File: core/hostport_top.sv
`include "hostport_params.svh"
module hostport_top (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 data_strobe_n_i,
  input  wire logic                 rw_i,
  input  wire logic                 interrupt_ack_n_i,
  input  wire logic                 chain_enable_in_n_i,
  input  wire logic                 bus_multiplex_select_i,
  input  wire logic                 addr_strobe_i,
  input  wire hostport_pkg::rsel_t  register_select_i,
  input  wire hostport_pkg::byte_t  data_lines_i,
  output      hostport_pkg::byte_t  data_lines_o,
  output      logic                 data_lines_oe_o,
  output      logic                 transfer_ack_n_o,
  output      logic                 transfer_ack_oe_o,
  output      logic                 irq_n_o,
  output      logic                 irq_oe_o,
  output      logic                 chain_enable_out_n_o,
  input  wire hostport_pkg::byte_t  general_purpose_lines_i,
  output      hostport_pkg::byte_t  general_purpose_lines_o,
  output      hostport_pkg::byte_t  general_purpose_lines_oe_o,
  input  wire logic [1:0]           timer_gate_inputs_i,
  input  wire logic [3:0]           timer_cycle_i,
  input  wire hostport_pkg::byte_t  int_src_i,
  input  wire logic                 rx_buffer_full_i,
  input  wire logic                 tx_buffer_empty_i,
  output      logic [3:0]           timer_toggle_outputs_o,
  output      logic [3:0]           timer_run_o,
  output      logic                 rx_enable_o,
  output      logic                 tx_enable_o,
  output      logic                 receive_dma_ready_n_o,
  output      logic                 send_dma_ready_n_o
);
  import hostport_pkg::*;
  bus_state_e   state_r;
  byte_t        regs_r [`REG_COUNT];
  logic [15:0]  ipr_r;
  byte_t        gp_prev_r;
  logic [1:0]   gate_prev_r;
  byte_t        data_d1_r, data_d2_r;
  rsel_t        rsel_d1_r, rsel_d2_r;
  logic         rw_d1_r, rw_d2_r;
  rsel_t        mpx_addr_r;
  rsel_t        addr_r;
  logic         is_wr_r, is_interrupt_ack_n_r;
  byte_t        shadow_r;
  logic [3:0]   ch_r;
  logic         tx_en_r;
  logic         cs_s, ds_s, interrupt_ack_n_s, iei_s, as_s;
  logic         go, acc_end, commit_wr, commit_interrupt_ack_n, irq_pend;
  logic [15:0]  ier, imr, events;
  byte_t        rdata, gp_edge;
  logic [1:0]   gate_edge;
  rsel_t        addr_cur;
  // synchronise the asynchronous bus strobes
  hostport_sync_if #(.W(5)) sif ();
  assign sif.raw = {addr_strobe_i, chain_enable_in_n_i, interrupt_ack_n_i,
                    data_strobe_n_i, cs_n_i};
  hostport_sync #(.W(5), .DEPTH(`SYNC_STAGES)) u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .port   (sif.dut)
  );
  assign {as_s, iei_s, interrupt_ack_n_s, ds_s, cs_s} = sif.synced;
  function automatic logic [3:0] top_ch(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) r = 4'(i);
    end
    return r;
  endfunction : top_ch
  // data and select delayed to line up with the strobe synchroniser
  always_ff @(posedge clk_i) begin
    data_d1_r <= data_lines_i;
    data_d2_r <= data_d1_r;
    rsel_d1_r <= register_select_i;
    rsel_d2_r <= rsel_d1_r;
    rw_d1_r   <= rw_i;
    rw_d2_r   <= rw_d1_r;
  end
  // address latched from shared lines while the address strobe is high
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mpx_addr_r <= '0;
    end else if (bus_multiplex_select_i && as_s) begin
      mpx_addr_r <= data_d2_r[4:0];
    end
  end
  assign addr_cur = bus_multiplex_select_i ? mpx_addr_r : rsel_d2_r;
  assign ier      = {regs_r[`RI_IERA], regs_r[`RI_IERB]};
  assign imr      = {regs_r[`RI_MASK_REG_A], regs_r[`RI_MASK_REG_B]};
  assign irq_pend = |(ipr_r & imr);
  // cs wins if the master breaks the exclusive-select contract
  assign go = !ds_s && (!cs_s || (!interrupt_ack_n_s && !iei_s));
  assign acc_end = ds_s || (is_interrupt_ack_n_r ? interrupt_ack_n_s : cs_s);
  assign commit_wr   = (state_r == S_WAIT) && acc_end && is_wr_r;
  assign commit_interrupt_ack_n = (state_r == S_WAIT) && acc_end && is_interrupt_ack_n_r;
  always_comb begin
    rdata = 8'h00;
    case (addr_r)
      `RI_GPIP: begin
        rdata = (regs_r[`RI_DDR] & regs_r[`RI_GPIP]) |
                (~regs_r[`RI_DDR] & general_purpose_lines_i);
      end
      `RI_PENDING_REG_A: rdata = ipr_r[15:8];
      `RI_PENDING_REG_B: rdata = ipr_r[7:0];
      default: begin
        if (addr_r < 5'(`REG_COUNT)) rdata = regs_r[addr_r];
      end
    endcase
  end
  // bus handshake
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r           <= S_IDLE;
      addr_r            <= '0;
      is_wr_r           <= 1'b0;
      is_interrupt_ack_n_r         <= 1'b0;
      shadow_r          <= 8'h00;
      ch_r              <= 4'h0;
      data_lines_o      <= 8'h00;
      data_lines_oe_o   <= 1'b0;
      transfer_ack_n_o  <= 1'b1;
      transfer_ack_oe_o <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          transfer_ack_oe_o <= 1'b0;
          if (go) begin
            addr_r    <= addr_cur;
            is_interrupt_ack_n_r <= cs_s;
            is_wr_r   <= !cs_s && !rw_d2_r;
            if (cs_s && !irq_pend) begin
              state_r <= S_PASS;
            end else if (cs_s) begin
              ch_r    <= top_ch(ipr_r & imr);
              state_r <= S_DRIVE;
            end else if (!rw_d2_r) begin
              shadow_r          <= data_d2_r;
              transfer_ack_n_o  <= 1'b0;
              transfer_ack_oe_o <= 1'b1;
              state_r           <= S_WAIT;
            end else begin
              state_r <= S_DRIVE;
            end
          end
        end
        S_DRIVE: begin
          data_lines_o    <= is_interrupt_ack_n_r ? {regs_r[`RI_VR][7:4], ch_r}
                                       : rdata;
          data_lines_oe_o <= 1'b1;
          state_r         <= S_WAIT;
        end
        S_WAIT: begin
          // ack only once the data lines already carry the value
          if (data_lines_oe_o || is_wr_r) begin
            transfer_ack_n_o  <= 1'b0;
            transfer_ack_oe_o <= 1'b1;
          end
          // keep last sample before the strobe rises
          if (is_wr_r && !ds_s) shadow_r <= data_d2_r;
          if (acc_end) begin
            transfer_ack_n_o <= 1'b1;
            data_lines_oe_o  <= 1'b0;
            state_r          <= S_RELEASE;
          end
        end
        S_PASS: begin
          if (acc_end) state_r <= S_IDLE;
        end
        S_RELEASE: begin
          transfer_ack_oe_o <= 1'b0;
          state_r           <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
  // register file; timer data, serial data and TSR survive reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        if (!(i >= `RI_TADR && i <= `RI_TDDR) && i != `RI_UDR &&
            i != `RI_TSR) begin
          regs_r[i] <= 8'h00;
        end
      end
      regs_r[`RI_VR] <= `VR_RST;
    end else if (commit_wr && addr_r < 5'(`REG_COUNT) &&
                 addr_r != `RI_PENDING_REG_A && addr_r != `RI_PENDING_REG_B) begin
      regs_r[addr_r] <= shadow_r;
    end
  end
  // edge detection on lines and gate inputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gp_prev_r   <= 8'h00;
      gate_prev_r <= 2'b00;
    end else begin
      gp_prev_r   <= general_purpose_lines_i;
      gate_prev_r <= timer_gate_inputs_i;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      gp_edge[i] = regs_r[`RI_AER][i]
                   ? (general_purpose_lines_i[i] && !gp_prev_r[i])
                   : (!general_purpose_lines_i[i] && gp_prev_r[i]);
    end
    gate_edge[0] = regs_r[`RI_AER][4]
                   ? (timer_gate_inputs_i[0] && !gate_prev_r[0])
                   : (!timer_gate_inputs_i[0] && gate_prev_r[0]);
    gate_edge[1] = regs_r[`RI_AER][3]
                   ? (timer_gate_inputs_i[1] && !gate_prev_r[1])
                   : (!timer_gate_inputs_i[1] && gate_prev_r[1]);
    events = {int_src_i, gp_edge};
    // gates take over the slots of lines 4 and 3
    if (regs_r[`RI_FIRST_TIMER_CONTROL][`TMODE_BIT]) events[4] = gate_edge[0];
    if (regs_r[`RI_SECOND_TIMER_CONTROL][`TMODE_BIT]) events[3] = gate_edge[1];
  end

  // pending bits: a new event beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ipr_r <= 16'h0000;
    end else begin
      ipr_r <= (ipr_r
                & ~({16{commit_wr && addr_r == `RI_PENDING_REG_A}} & {~shadow_r, 8'h00})
                & ~({16{commit_wr && addr_r == `RI_PENDING_REG_B}} & {8'h00, ~shadow_r})
                & ~({16{commit_interrupt_ack_n}} & (16'h0001 << ch_r)))
               | (events & ier);
    end
  end

  // interrupt request and daisy chain
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_n_o              <= 1'b1;
      irq_oe_o             <= 1'b0;
      chain_enable_out_n_o <= 1'b1;
    end else begin
      irq_n_o              <= !irq_pend;
      irq_oe_o             <= irq_pend;
      chain_enable_out_n_o <= !(!iei_s && !irq_pend);
    end
  end

  // general purpose lines
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      general_purpose_lines_o    <= 8'h00;
      general_purpose_lines_oe_o <= 8'h00;
    end else begin
      general_purpose_lines_o    <= regs_r[`RI_GPIP];
      general_purpose_lines_oe_o <= regs_r[`RI_DDR];
    end
  end

  // timer outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_toggle_outputs_o <= 4'h0;
    end else begin
      timer_toggle_outputs_o <= timer_toggle_outputs_o ^ timer_cycle_i;
      if (commit_wr && addr_r == `RI_FIRST_TIMER_CONTROL) begin
        timer_toggle_outputs_o[0] <= 1'b0;
      end
      if (commit_wr && addr_r == `RI_SECOND_TIMER_CONTROL) begin
        timer_toggle_outputs_o[1] <= 1'b0;
      end
    end
  end

  // transmit enable lives apart since TSR keeps its value over reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_en_r <= 1'b0;
    end else if (commit_wr && addr_r == `RI_TSR) begin
      tx_en_r <= shadow_r[`TX_EN_BIT];
    end
  end

  // run and enable status towards timer and serial blocks
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_run_o <= 4'h0;
      rx_enable_o <= 1'b0;
      tx_enable_o <= 1'b0;
    end else begin
      timer_run_o <= {|regs_r[`RI_TCDCR][2:0], |regs_r[`RI_TCDCR][6:4],
                      |regs_r[`RI_SECOND_TIMER_CONTROL][3:0], |regs_r[`RI_FIRST_TIMER_CONTROL][3:0]};
      rx_enable_o <= regs_r[`RI_RSR][`RX_EN_BIT];
      tx_enable_o <= tx_en_r;
    end
  end

  // dma ready pins
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      receive_dma_ready_n_o <= 1'b1;
      send_dma_ready_n_o    <= 1'b1;
    end else begin
      receive_dma_ready_n_o <= !rx_buffer_full_i;
      send_dma_ready_n_o    <= !tx_buffer_empty_i;
    end
  end
endmodule : hostport_top

// File: test/hostport_assertions.sv
module hostport_assertions (
  input wire logic                clk_i,
  input wire logic                srst_i,
  input wire logic                cs_n_i,
  input wire logic                interrupt_ack_n_i,
  input wire logic                chain_enable_in_n_i,
  input wire logic                data_lines_oe_o,
  input wire logic                transfer_ack_n_o,
  input wire logic                transfer_ack_oe_o,
  input wire logic                irq_n_o,
  input wire logic                irq_oe_o,
  input wire logic                chain_enable_out_n_o,
  input wire hostport_pkg::byte_t general_purpose_lines_oe_o,
  input wire logic [3:0]          timer_cycle_i,
  input wire logic [3:0]          timer_toggle_outputs_o,
  input wire logic [3:0]          timer_run_o,
  input wire logic                rx_enable_o,
  input wire logic                tx_enable_o,
  input wire logic                rx_buffer_full_i,
  input wire logic                receive_dma_ready_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import hostport_pkg::*;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // ack starts no sooner than two sync stages and one decode edge after the raw select
  chk_ack_select: assert property (
    !transfer_ack_n_o && transfer_ack_oe_o |-> $past(!cs_n_i, 3) ||
    $past(!interrupt_ack_n_i && !chain_enable_in_n_i, 3)
  ) else $error("ack driven without select");
  chk_read_setup: assert property (
    $fell(transfer_ack_n_o) && data_lines_oe_o |-> $past(data_lines_oe_o)
  ) else $error("read ack before data");
  chk_ack_release: assert property (
    $rose(transfer_ack_n_o) |-> transfer_ack_oe_o ##1
    (!transfer_ack_oe_o && !data_lines_oe_o)
  ) else $error("ack not driven high then released");
  chk_irq_drain: assert property (
    irq_oe_o == !irq_n_o
  ) else $error("irq open drain enable wrong");
  // chain out and irq are registered from the same pending term
  chk_chain_own: assert property (
    !chain_enable_out_n_o |-> irq_n_o
  ) else $error("chain passed with own request");
  chk_chain_quiet: assert property (
    !chain_enable_out_n_o && !interrupt_ack_n_i &&
    $past(!interrupt_ack_n_i, 4) |-> !transfer_ack_oe_o && !data_lines_oe_o
  ) else $error("bus driven while passing chain");
  chk_reset_state: assert property (
    $past(srst_i) |-> timer_toggle_outputs_o == 4'h0 &&
    timer_run_o == 4'h0 && !rx_enable_o && !tx_enable_o && irq_n_o &&
    general_purpose_lines_oe_o == 8'h00
  ) else $error("state not cleared by reset");
  chk_dma_follow: assert property (
    !$past(srst_i) |-> receive_dma_ready_n_o == !$past(rx_buffer_full_i)
  ) else $error("receive dma ready wrong");
  chk_timer_toggle: assert property (
    (timer_cycle_i & timer_run_o) != 4'h0 |=>
    timer_toggle_outputs_o != $past(timer_toggle_outputs_o)
  ) else $error("timer output did not toggle");
endmodule : hostport_assertions

// File: test/host_master_model.sv
module host_master_model (
  input  wire logic                clk_i,
  input  wire logic                ack_n_i,
  input  wire logic                ack_oe_i,
  input  wire hostport_pkg::byte_t rdata_i,
  output logic                     cs_n_o,
  output logic                     ds_n_o,
  output logic                     rw_o,
  output logic                     interrupt_ack_n_n_o,
  output hostport_pkg::rsel_t      sel_o,
  output hostport_pkg::byte_t      wdata_o,
  output logic                     as_o,
  output logic                     got_o,
  output hostport_pkg::byte_t      got_d_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import hostport_pkg::*;

  initial begin
    {cs_n_o, ds_n_o, rw_o, interrupt_ack_n_n_o, got_o} = 5'b11110;
    sel_o = 5'h00;
    // strobe pin idles low outside multiplexed mode
    as_o = 1'b0;
    wdata_o = 8'h00;
    got_d_o = 8'h00;
  end

  // kind 0 write, 1 read, 2 interrupt ack; a silent device times out
  task automatic xfer(input int kind, input rsel_t sel, input byte_t wd);
    int n;
    n = 0;
    @(posedge clk_i);
    #2;
    sel_o = sel;
    wdata_o = (kind == 0) ? wd : ~wdata_o;
    rw_o = (kind != 0);
    cs_n_o = (kind == 2);
    interrupt_ack_n_n_o = (kind != 2);
    ds_n_o = 1'b0;
    while (!(ack_oe_i === 1'b1 && ack_n_i === 1'b0) && n < 24) begin
      @(posedge clk_i);
      n++;
    end
    if (n < 24 && kind != 0) begin
      got_d_o = rdata_i;
      got_o = 1'b1;
      #1;
      got_o = 1'b0;
    end
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
    #2;
    {cs_n_o, ds_n_o, interrupt_ack_n_n_o} = 3'b111;
    repeat (6) @(posedge clk_i);
    #2;
  endtask : xfer

  // multiplexed address phase: index on the shared lines, strobe high
  task automatic addr_phase(input rsel_t a);
    @(posedge clk_i);
    #2;
    wdata_o = {3'b000, a};
    as_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #2;
    as_o = 1'b0;
  endtask : addr_phase
endmodule : host_master_model

// File: test/peripheral_host_bus_port_tb.sv
`include "hostport_params.svh"
module peripheral_host_bus_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hostport_pkg::*;

  logic  clk_i, srst_i, cs_n_i, data_strobe_n_i, rw_i, interrupt_ack_n_i;
  logic  chain_enable_in_n_i, bus_multiplex_select_i, addr_strobe_i, got;
  logic  data_lines_oe_o, transfer_ack_n_o, transfer_ack_oe_o, irq_n_o;
  logic  irq_oe_o, chain_enable_out_n_o, rx_buffer_full_i, rx_enable_o;
  logic  tx_buffer_empty_i, tx_enable_o;
  logic  receive_dma_ready_n_o, send_dma_ready_n_o;
  logic  [1:0] timer_gate_inputs_i;
  logic  [3:0] timer_cycle_i, timer_toggle_outputs_o, timer_run_o;
  rsel_t register_select_i;
  byte_t data_lines_i, data_lines_o, int_src_i, got_d;
  byte_t general_purpose_lines_i, general_purpose_lines_o;
  byte_t general_purpose_lines_oe_o;
  byte_t exp_q[$];
  int    fail_count = 0;
  int    cmp_count = 0;
  rsel_t regs[7] = '{`RI_IERA, `RI_IERB, `RI_MASK_REG_A, `RI_MASK_REG_B, `RI_AER,
                     `RI_SCR, `RI_DDR};

  // undriven pins settle to a fixed outside pattern
  assign general_purpose_lines_i =
    (general_purpose_lines_oe_o & general_purpose_lines_o) |
    (~general_purpose_lines_oe_o & 8'h5a);

  hostport_top i_dut (.*);

  host_master_model i_host (
    .clk_i    (clk_i),
    .ack_n_i  (transfer_ack_n_o),
    .ack_oe_i (transfer_ack_oe_o),
    // a released bus reads back inverted, so a bare ack cannot pass
    .rdata_i  (data_lines_oe_o ? data_lines_o : ~data_lines_o),
    .cs_n_o   (cs_n_i),
    .ds_n_o   (data_strobe_n_i),
    .rw_o     (rw_i),
    .interrupt_ack_n_n_o (interrupt_ack_n_i),
    .sel_o    (register_select_i),
    .wdata_o  (data_lines_i),
    .as_o     (addr_strobe_i),
    .got_o    (got),
    .got_d_o  (got_d)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run();
    // a read or vector left unanswered is a mismatch
    if (exp_q.size() != 0) fail_count++;
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : ticks

  task automatic wr(input rsel_t s, input byte_t d);
    i_host.xfer(0, s, d);
  endtask : wr

  task automatic rd(input rsel_t s, input byte_t e);
    exp_q.push_back(e);
    i_host.xfer(1, s, 8'h00);
  endtask : rd

  task automatic interrupt_ack_n(input logic hit, input byte_t e);
    if (hit) exp_q.push_back(e);
    i_host.xfer(2, 5'h00, 8'h00);
  endtask : interrupt_ack_n

  task automatic pulse(input byte_t v);
    int_src_i = v;
    ticks(1);
    int_src_i = 8'h00;
    ticks(3);
  endtask : pulse

  task automatic reset_check();
    srst_i = 1'b1;
    ticks(6);
    srst_i = 1'b0;
    ticks(1);
    check({timer_toggle_outputs_o, timer_run_o}, 8'h00);
    check({rx_enable_o, tx_enable_o, irq_n_o, irq_oe_o}, 4'h2);
    check(general_purpose_lines_oe_o, 8'h00);
    rd(`RI_VR, 8'h0f);
    rd(`RI_MASK_REG_B, 8'h00);
  endtask : reset_check

  // an ack that nobody expected meets an unknown and fails
  always @(posedge got)
    check(got_d, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

  initial begin
    #300us;
    fail_count++;
    complete_run();
  end

  initial begin
    byte_t d;
    int    k;
    void'($urandom(88352));
    {chain_enable_in_n_i, bus_multiplex_select_i} = 2'b00;
    {srst_i, rx_buffer_full_i, tx_buffer_empty_i} = 3'b100;
    {timer_gate_inputs_i, timer_cycle_i, int_src_i} = 14'h0000;
    reset_check();
    foreach (regs[i]) begin
      d = 8'($urandom);
      wr(regs[i], d);
      rd(regs[i], d);
    end
    check(general_purpose_lines_oe_o, d);
    wr(`RI_GPIP, 8'ha5);
    check(general_purpose_lines_o & d, 8'ha5 & d);
    wr(5'h18, 8'hff);
    rd(5'h18, 8'h00);
    rd(5'h1f, 8'h00);
    wr(`RI_RSR, 8'h01);
    wr(`RI_TSR, 8'h01);
    check({rx_enable_o, tx_enable_o}, 2'b11);
    bus_multiplex_select_i = 1'b1;
    i_host.addr_phase(5'h18);
    wr(5'h00, 8'h00);
    i_host.addr_phase(`RI_SCR);
    wr(5'h00, 8'h3c);
    i_host.addr_phase(`RI_SCR);
    rd(5'h00, 8'h3c);
    bus_multiplex_select_i = 1'b0;
    reset_check();
    for (int t = 0; t < 2; t++) begin
      wr(rsel_t'(`RI_FIRST_TIMER_CONTROL + t), 8'h01);
      k = 2 * $urandom_range(0, 2) + 1;
      repeat (k) begin
        timer_cycle_i[t] = 1'b1;
        ticks(1);
        timer_cycle_i[t] = 1'b0;
        ticks(1);
      end
      check(timer_toggle_outputs_o[t], 1'b1);
      wr(rsel_t'(`RI_FIRST_TIMER_CONTROL + t), 8'h01);
      check(timer_toggle_outputs_o[t], 1'b0);
    end
    repeat (4) begin
      {rx_buffer_full_i, tx_buffer_empty_i} = 2'($urandom);
      ticks(3);
      check(receive_dma_ready_n_o, !rx_buffer_full_i);
      check(send_dma_ready_n_o, !tx_buffer_empty_i);
    end
    wr(`RI_VR, 8'h40);
    wr(`RI_IERA, 8'hff);
    wr(`RI_MASK_REG_A, 8'hff);
    pulse(8'h84);
    check({irq_n_o, chain_enable_out_n_o}, 2'b01);
    interrupt_ack_n(1'b1, 8'h4f);
    check(irq_n_o, 1'b0);
    interrupt_ack_n(1'b1, 8'h4a);
    check({irq_n_o, chain_enable_out_n_o}, 2'b10);
    interrupt_ack_n(1'b0, 8'h00);
    pulse(8'h01);
    wr(`RI_MASK_REG_A, 8'h00);
    check(irq_n_o, 1'b1);
    wr(`RI_MASK_REG_A, 8'hff);
    check(irq_n_o, 1'b0);
    wr(`RI_PENDING_REG_A, 8'h00);
    check(irq_n_o, 1'b1);
    chain_enable_in_n_i = 1'b1;
    pulse(8'h02);
    interrupt_ack_n(1'b0, 8'h00);
    check({irq_n_o, chain_enable_out_n_o}, 2'b01);
    chain_enable_in_n_i = 1'b0;
    interrupt_ack_n(1'b1, 8'h49);
    wr(`RI_FIRST_TIMER_CONTROL, 8'h08);
    wr(`RI_IERB, 8'h10);
    wr(`RI_MASK_REG_B, 8'h10);
    timer_gate_inputs_i = 2'b01;
    ticks(2);
    timer_gate_inputs_i = 2'b00;
    ticks(3);
    check(irq_n_o, 1'b0);
    interrupt_ack_n(1'b1, 8'h44);
    complete_run();
  end
endmodule : peripheral_host_bus_port_tb

bind hostport_top hostport_assertions i_chk (.*);
